// ==== core/rcf_map.vh ====
/*
  Constants for the reset-cause flag register block: register indices,
  flag bit positions and values taken at power-on.
  Assumes it is included by bare name into a module that uses them.
*/
`ifndef RCF_MAP_VH
`define RCF_MAP_VH

// Register indices on the plain register port.
`define RCF_ADDR_CAUSE     4'h0
`define RCF_ADDR_INT_STAT  4'h1
`define RCF_ADDR_INT_MASK  4'h2

// Bit positions of the cause register.
`define RCF_BIT_STACK_OVERFLOW_FLAG     7
`define RCF_BIT_STACK_UNDERFLOW_FLAG     6
`define RCF_BIT_UNUSED     5
`define RCF_BIT_WDT_N      4
`define RCF_BIT_PIN_N      3
`define RCF_BIT_INSTR_N    2
`define RCF_BIT_POR_N      1
`define RCF_BIT_BOR_N      0

// Implemented bits of the cause register.
`define RCF_CAUSE_WMASK    8'hDF

// Cause register value after power-on (stack 0, wdt/pin/instr 1, por 0).
`define RCF_CAUSE_POR_VAL  8'h1C

// Bits forced by a brown-out: stacks to 0, wdt/pin/instr to 1, bor to 0.
`define RCF_BOR_CLR_MASK   8'hC1
`define RCF_BOR_SET_MASK   8'h1C

// Interrupt status layout: one sticky bit per cause event.
`define RCF_EV_STACK_OVERFLOW_FLAG      6
`define RCF_EV_STACK_UNDERFLOW_FLAG      5
`define RCF_EV_WDT         4
`define RCF_EV_PIN         3
`define RCF_EV_INSTR       2
`define RCF_EV_POR         1
`define RCF_EV_BOR         0
`define RCF_EV_RESET_VAL   7'h02

`endif

// ==== core/rcf_top.v ====
/*
  Reset-cause flag register with a plain register port and a sticky,
  maskable event interrupt.
  Assumes rst_n is the power-on reset of the block and that every cause
  event is a one-cycle pulse from reset-control logic on clk_sys.
*/
`timescale 1ns/1ps
`include "rcf_map.vh"

module rcf_top #(
  parameter ADDR_W = 4
) (
  // Clock and reset.
  input  wire              clk_sys,
  input  wire              rst_n,
  // Reset cause pulses from the reset controller.
  input  wire              stk_ovf_evt,
  input  wire              stk_unf_evt,
  input  wire              wdt_evt,
  input  wire              pin_evt,
  input  wire              instr_evt,
  input  wire              bor_evt,
  // Configuration word level.
  input  wire              stack_error_reset_enable,
  // Register port.
  input  wire [ADDR_W-1:0] reg_addr,
  input  wire [7:0]        reg_wdata,
  input  wire              reg_wr,
  input  wire              reg_rd,
  output reg  [7:0]        reg_rdata,
  // Flags and interrupt.
  output reg  [7:0]        reset_cause_flags,
  output reg               irq
);

  // Address match, shared by the write and read decoders.
  function addr_is;
    input [ADDR_W-1:0] a;
    input [3:0]        idx;
    begin
      // Low nibble must match and every upper address bit must be zero.
      addr_is = (a[3:0] == idx) && ~|(a >> 4);
    end
  endfunction

  reg  [7:0] cause_q;
  reg  [7:0] cause_d;
  reg  [6:0] ev_stat_q;
  reg  [6:0] ev_mask_q;
  reg  [7:0] rdata_d;
  wire [6:0] ev_raw;
  wire [6:0] ev_stat_d;
  wire       wr_cause;
  wire       wr_stat;
  wire       wr_mask;
  wire       stk_ovf_ok;
  wire       stk_unf_ok;

  // Stack errors only reset the core, and so only count, when enabled.
  assign stk_ovf_ok = stk_ovf_evt & stack_error_reset_enable;
  assign stk_unf_ok = stk_unf_evt & stack_error_reset_enable;

  assign wr_cause = reg_wr & addr_is(reg_addr, `RCF_ADDR_CAUSE);
  assign wr_stat  = reg_wr & addr_is(reg_addr, `RCF_ADDR_INT_STAT);
  assign wr_mask  = reg_wr & addr_is(reg_addr, `RCF_ADDR_INT_MASK);

  // Next cause value: software write first, then hardware on top so a
  // colliding event is never lost. A write only stores bits; nothing here
  // feeds back into any reset path.
  always @* begin
    cause_d = cause_q;
    if (wr_cause) begin
      cause_d = reg_wdata & `RCF_CAUSE_WMASK;
    end
    if (bor_evt) begin
      cause_d = (cause_d & ~`RCF_BOR_CLR_MASK) | `RCF_BOR_SET_MASK;
    end
    if (stk_ovf_ok) begin
      cause_d[`RCF_BIT_STACK_OVERFLOW_FLAG] = 1'b1;
    end
    if (stk_unf_ok) begin
      cause_d[`RCF_BIT_STACK_UNDERFLOW_FLAG] = 1'b1;
    end
    if (wdt_evt) begin
      cause_d[`RCF_BIT_WDT_N] = 1'b0;
    end
    if (pin_evt) begin
      cause_d[`RCF_BIT_PIN_N] = 1'b0;
    end
    if (instr_evt) begin
      cause_d[`RCF_BIT_INSTR_N] = 1'b0;
    end
    cause_d[`RCF_BIT_UNUSED] = 1'b0;
  end

  // Power-on marks the power flag and sets the defaults of the others.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      cause_q <= `RCF_CAUSE_POR_VAL;
    end else begin
      cause_q <= cause_d;
    end
  end

  // Event vector in interrupt status layout.
  assign ev_raw[`RCF_EV_STACK_OVERFLOW_FLAG] = stk_ovf_ok;
  assign ev_raw[`RCF_EV_STACK_UNDERFLOW_FLAG] = stk_unf_ok;
  assign ev_raw[`RCF_EV_WDT]    = wdt_evt;
  assign ev_raw[`RCF_EV_PIN]    = pin_evt;
  assign ev_raw[`RCF_EV_INSTR]  = instr_evt;
  assign ev_raw[`RCF_EV_POR]    = 1'b0;
  assign ev_raw[`RCF_EV_BOR]    = bor_evt;

  // Sticky status, write one to clear; a new event wins over the clear.
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_stat
      assign ev_stat_d[gi] = ev_raw[gi] |
                             (ev_stat_q[gi] & ~(wr_stat & reg_wdata[gi]));
    end
  endgenerate

  // Status starts with the power-on event pending; mask starts closed.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      ev_stat_q <= `RCF_EV_RESET_VAL;
      ev_mask_q <= 7'h00;
      irq       <= 1'b0;
    end else begin
      ev_stat_q <= ev_stat_d;
      if (wr_mask) begin
        ev_mask_q <= reg_wdata[6:0];
      end
      irq <= |(ev_stat_d & (wr_mask ? reg_wdata[6:0] : ev_mask_q));
    end
  end

  // Read mux; unmapped indices read zero.
  always @* begin
    rdata_d = 8'h00;
    if (addr_is(reg_addr, `RCF_ADDR_CAUSE)) begin
      rdata_d = cause_q;
    end else if (addr_is(reg_addr, `RCF_ADDR_INT_STAT)) begin
      rdata_d = {1'b0, ev_stat_q};
    end else if (addr_is(reg_addr, `RCF_ADDR_INT_MASK)) begin
      rdata_d = {1'b0, ev_mask_q};
    end
  end

  // Read data stands for the one cycle after the strobe, zero otherwise.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata         <= 8'h00;
      reset_cause_flags <= `RCF_CAUSE_POR_VAL;
    end else begin
      reg_rdata         <= reg_rd ? rdata_d : 8'h00;
      reset_cause_flags <= cause_d;
    end
  end

endmodule // rcf_top

// ==== verif/rcf_properties.sv ====
/* Checker on the rcf_top ports: cause flag updates and writes.
   Assumes a bind to rcf_top with its default address width. */
`timescale 1ns/1ps
module rcf_chk (
  // Clock, reset and events.
  input wire       clk_sys,
  input wire       rst_n,
  input wire       stk_ovf_evt,
  input wire       stk_unf_evt,
  input wire       wdt_evt,
  input wire       pin_evt,
  input wire       instr_evt,
  input wire       bor_evt,
  input wire       stack_error_reset_enable,
  // Register port and flags.
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire [7:0] reset_cause_flags
);
  // Stack events count only when the stack error reset is enabled.
  wire hw_en = wdt_evt | pin_evt | instr_evt | bor_evt
    | ((stk_ovf_evt | stk_unf_evt) & stack_error_reset_enable);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // A plain cause write, and a cycle that may not touch the flags.
  sequence s_wr;
    reg_wr && reg_addr == 4'h0 && !hw_en;
  endsequence
  sequence s_quiet;
    !hw_en && !(reg_wr && reg_addr == 4'h0);
  endsequence
  // The other causes are applied on top of a brown-out, yet these checks exclude it.
  AST_HOLD: assert property (s_quiet |=>
    $stable(reset_cause_flags)) else $error("flags moved");
  AST_WR: assert property (s_wr |=>
    reset_cause_flags == ($past(reg_wdata) & 8'hdf)) else $error("write");
  AST_BIT5: assert property (!reset_cause_flags[5])
    else $error("bit 5 set");
  AST_OVF: assert property (stk_ovf_evt && stack_error_reset_enable
    && !bor_evt |=> reset_cause_flags[7]) else $error("overflow flag");
  AST_WDT: assert property (wdt_evt && !bor_evt |=>
    !reset_cause_flags[4]) else $error("watchdog flag");
  AST_PIN: assert property (pin_evt && !bor_evt |=>
    !reset_cause_flags[3]) else $error("pin flag");
  AST_INS: assert property (instr_evt && !bor_evt |=>
    !reset_cause_flags[2]) else $error("instruction flag");
  AST_BOR: assert property (bor_evt |=>
    (reset_cause_flags & 8'hfd) == 8'h1c) else $error("brown-out");
endmodule // rcf_chk

// ==== verif/rcf_tb_top.sv ====
/* Bench for rcf_top over its register port and event pulses.
   Assumes rcf_top and rcf_chk are compiled before it. */
`timescale 1ns/1ps
bind rcf_top rcf_chk i_chk (.*);
module rcf_tb_top;
  logic       clk_sys = 0;
  logic       rst_n = 0;
  logic [5:0] ev = 0;
  logic       stack_error_reset_enable = 0;
  logic       reg_wr = 0;
  logic       reg_rd = 0;
  logic [3:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0;
  wire  [7:0] reg_rdata;
  wire  [7:0] reset_cause_flags;
  wire        irq;
  wire        stk_ovf_evt, stk_unf_evt, wdt_evt, pin_evt, instr_evt;
  wire        bor_evt;
  int         bad_count = 0;
  int         compares = 0;
  // Event order: overflow, underflow, watchdog, pin, instruction, bor.
  logic [5:0] evs [7] = '{6'h08, 6'h04, 6'h02, 6'h20, 6'h20, 6'h10, 6'h01};
  logic [7:0] exps [7] = '{8'h0f, 8'h07, 8'h03, 8'h03, 8'h83, 8'hc3, 8'h1e};
  assign {stk_ovf_evt, stk_unf_evt, wdt_evt, pin_evt, instr_evt, bor_evt} = ev;
  rcf_top i_dut (.*);
  initial forever #5 clk_sys = ~clk_sys;
  // A hang is cut short and counted as a mismatch.
  initial begin
    #100000;
    bad_count++;
    print_verdict;
  end
  task chk(input [7:0] g, input [7:0] x);
    compares++;
    if (g !== x) begin
      bad_count++;
      $display("BAD at %0t: got %h exp %h", $time, g, x);
    end
  endtask
  // Strobes are one cycle; every task starts just after an edge.
  task wr(input [3:0] a, input [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge clk_sys);
    reg_wr <= 0;
  endtask
  task rd(input [3:0] a, input [7:0] x);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk_sys);
    reg_rd <= 0;
    #1 chk(reg_rdata, x);
    @(posedge clk_sys);
  endtask
  task pulse(input [5:0] e);
    ev <= e;
    @(posedge clk_sys);
    ev <= 0;
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1;
    rd(4'h0, 8'h1c);
    rd(4'h5, 8'h00);
    wr(4'h0, 8'hff);
    rd(4'h0, 8'hdf);
    $display("test reset done");
    ev <= 6'h08;
    wr(4'h0, 8'hff);
    ev <= 0;
    rd(4'h0, 8'hcf);
    wr(4'h0, 8'h1f);
    foreach (evs[i]) begin
      if (i == 4) stack_error_reset_enable <= 1;
      pulse(evs[i]);
      rd(4'h0, exps[i]);
    end
    $display("test flags done");
    wr(4'h1, 8'h7f);
    wr(4'h2, 8'h10);
    pulse(6'h04);
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clk_sys);
    pulse(6'h08);
    #1 chk({7'h00, irq}, 8'h01);
    @(posedge clk_sys);
    wr(4'h1, 8'h10);
    #1 chk({7'h00, irq}, 8'h00);
    @(posedge clk_sys);
    $display("test irq done");
    print_verdict;
  end
endmodule // rcf_tb_top
